// ### rtl/tws_defs.vh
// register offsets, field positions, reset values and timing for the timer/watchdog/sleep block
// assumes an 8-bit register view carried in the low byte of a 32-bit wishbone word
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
// ==================================================
// register byte offsets
`define TWS_OFF_TIMER     6'h00
`define TWS_OFF_TCFG      6'h04
`define TWS_OFF_P5DIR     6'h08
`define TWS_OFF_P6DIR     6'h0C
`define TWS_OFF_P7DIR     6'h10
`define TWS_OFF_P6WAKE    6'h14
`define TWS_OFF_WDSLP     6'h18
`define TWS_OFF_IMASK     6'h1C
`define TWS_OFF_IFLAG     6'h20
`define TWS_OFF_OPS       6'h24
`define TWS_OFF_STATUS    6'h28
`define TWS_OFF_P5OUT     6'h2C
`define TWS_OFF_P6OUT     6'h30
`define TWS_OFF_P7OUT     6'h34
// ==================================================
// field positions
`define TWS_TCFG_PULLN    7
`define TWS_TCFG_GIE      6
`define TWS_TCFG_SRC      5
`define TWS_TCFG_EDGE     4
`define TWS_TCFG_OWNER    3
`define TWS_WD_ODE        6
`define TWS_WD_WATCHDOG_ENABLE       5
`define TWS_WD_RUN        4
`define TWS_WD_ROC        3
`define TWS_WD_WAKEN      0
`define TWS_IRQ_EXT       3
`define TWS_IRQ_TMR       0
`define TWS_OP_GON        0
`define TWS_OP_GOFF       1
`define TWS_OP_RETURN_FROM_IRQ_OP       2
`define TWS_OP_WDCLR      3
`define TWS_OP_SLEEP      4
`define TWS_OP_TAKEN      5
// ==================================================
// reset values and write masks
`define TWS_RST_TCFG      8'hBF
`define TWS_RST_DIR       8'hFF
`define TWS_RST_P6WAKE    8'hFF
`define TWS_RST_WDSLP     8'h31
`define TWS_RST_ZERO      8'h00
`define TWS_WDSLP_MASK    8'h79
`define TWS_IRQ_MASK      8'h09
// ==================================================
// timing
`define TWS_CLK_MHZ       125
`define TWS_OST_TIME_US   18000
`define TWS_WDT_TIME_US   18000
`define TWS_CNT_W         22
`endif

// ### rtl/tws_timer_watchdog.v
// timer/counter, watchdog, shared prescaler, port control, sleep and reset sequencing
// assumes a classic wishbone master on clk_i and pins arriving asynchronously
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "tws_defs.vh"

module tws_timer_watchdog #(
  parameter                  CNT_W   = `TWS_CNT_W,
  parameter [CNT_W-1:0]      OST_CYC = `TWS_OST_TIME_US * `TWS_CLK_MHZ,
  parameter [CNT_W-1:0]      WDT_CYC = `TWS_WDT_TIME_US * `TWS_CLK_MHZ
) (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [31:0]         wb_adr_i,
  input  wire [31:0]         wb_dat_i,
  input  wire [3:0]          wb_sel_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  input  wire                reset_pin_n_i,
  input  wire                timer_pin_i,
  input  wire                ext_irq_n_i,
  input  wire                clk_div_opt_i,
  input  wire                watchdog_fuse_option_i,
  input  wire [7:0]          p5_i,
  input  wire [7:0]          p6_i,
  input  wire [7:0]          p7_i,
  output reg  [7:0]          p5_o,
  output reg  [7:0]          p5_oe_n_o,
  output reg  [7:0]          p6_o,
  output reg  [7:0]          p6_oe_n_o,
  output reg  [7:0]          p7_o,
  output reg  [7:0]          p7_oe_n_o,
  output reg  [7:0]          p6_pullup_o,
  output reg  [1:0]          p7_pullup_o,
  output reg                 irq_request_o,
  output reg                 core_reset_o,
  output reg                 core_stall_o,
  output reg                 osc_stop_o
);

  // ==================================================
  // input synchronisers
  reg  [7:0]          p5_s1_q, p5_s2_q, p6_s1_q, p6_s2_q, p7_s1_q, p7_s2_q;
  reg  [4:0]          misc_s1_q, misc_s2_q;
  reg                 tpin_prev_q, ext_prev_q;

  always @(posedge clk_i) begin
    p5_s1_q   <= p5_i;
    p5_s2_q   <= p5_s1_q;
    p6_s1_q   <= p6_i;
    p6_s2_q   <= p6_s1_q;
    p7_s1_q   <= p7_i;
    p7_s2_q   <= p7_s1_q;
    misc_s1_q <= {reset_pin_n_i, timer_pin_i, ext_irq_n_i, clk_div_opt_i, watchdog_fuse_option_i};
    misc_s2_q <= misc_s1_q;
    tpin_prev_q <= misc_s2_q[3];
    ext_prev_q  <= misc_s2_q[2];
  end

  wire                pin_rst_n  = misc_s2_q[4];
  wire                tpin       = misc_s2_q[3];
  wire                ext_n      = misc_s2_q[2];
  wire                div_opt    = misc_s2_q[1];
  wire                wdt_fuse   = misc_s2_q[0];

  // ==================================================
  // registers
  reg  [7:0]          timer_q, tcfg_q, p5dir_q, p6dir_q, p7dir_q, p6wake_q;
  reg  [7:0]          wdslp_q, imask_q, iflag_q, p5out_q, p6out_q, p7out_q;
  reg  [7:0]          presc_q;
  reg  [CNT_W-1:0]    wdt_base_q, ost_cnt_q;
  reg                 ost_is_reset_q, sleep1_q, wdt_force_q;
  reg  [1:0]          div_q;
  reg                 ack_q;

  wire                sys_rst    = core_reset_o;
  wire                owner_wdt  = tcfg_q[`TWS_TCFG_OWNER];
  wire [2:0]          ratio      = tcfg_q[2:0];
  wire                osc_run    = wdslp_q[`TWS_WD_RUN];

  // ==================================================
  // wishbone decode, writes land at the edge the master sees ack
  wire                bus_req    = wb_cyc_i & wb_stb_i;
  wire                wr_fire    = bus_req & wb_we_i & ack_q & wb_sel_i[0];
  wire [5:0]          adr        = wb_adr_i[5:0];
  wire                adr_hi_ok  = (wb_adr_i[31:6] == 26'h0000000);
  wire [7:0]          wdat       = wb_dat_i[7:0];

  wire                wr_timer   = wr_fire & adr_hi_ok & (adr == `TWS_OFF_TIMER);
  wire                wr_tcfg    = wr_fire & adr_hi_ok & (adr == `TWS_OFF_TCFG);
  wire                wr_wdslp   = wr_fire & adr_hi_ok & (adr == `TWS_OFF_WDSLP);
  wire                wr_iflag   = wr_fire & adr_hi_ok & (adr == `TWS_OFF_IFLAG);
  wire                wr_ops     = wr_fire & adr_hi_ok & (adr == `TWS_OFF_OPS);
  wire [7:0]          ops        = wr_ops ? wdat : 8'h00;

  wire                op_wdclr   = ops[`TWS_OP_WDCLR];
  wire                op_sleep   = ops[`TWS_OP_SLEEP];

  // ==================================================
  // instruction clock and timer count source
  wire                instr_tick = (div_opt ? (div_q == 2'h3) : div_q[0]) & osc_run;
  wire                tpin_edge  = tcfg_q[`TWS_TCFG_EDGE] ? (tpin_prev_q & ~tpin)
                                                          : (~tpin_prev_q & tpin);
  wire                tsrc_evt   = tcfg_q[`TWS_TCFG_SRC] ? tpin_edge : instr_tick;

  // ==================================================
  // shared prescaler: timer needs 2^(n+1) events, watchdog 2^n
  wire [7:0]          tmr_mask   = (8'h02 << ratio) - 8'h01;
  wire [7:0]          wdt_mask   = (8'h01 << ratio) - 8'h01;
  wire                wdt_evt    = (wdt_base_q == WDT_CYC - 1'b1);
  wire                presc_evt  = owner_wdt ? wdt_evt : tsrc_evt;
  wire [7:0]          presc_mask = owner_wdt ? wdt_mask : tmr_mask;
  wire                presc_full = ((presc_q & presc_mask) == presc_mask);
  wire                timer_inc  = owner_wdt ? tsrc_evt : (tsrc_evt & presc_full);
  wire                wdt_expire = owner_wdt ? (wdt_evt & presc_full) : wdt_evt;
  wire                wdt_active = wdt_force_q | (~wdt_fuse & wdslp_q[`TWS_WD_WATCHDOG_ENABLE]);
  wire                wdt_clear  = op_wdclr | op_sleep;
  wire                wdt_reset  = wdt_active & wdt_expire & ~wdt_clear;

  // ==================================================
  // wake and reset sources
  wire [7:0]          p6_wake    = ~p6_s2_q & ~p6wake_q;
  wire                p7_wake    = ~(p7_s2_q[4] & p7_s2_q[5]) & ~wdslp_q[`TWS_WD_WAKEN];
  wire                wake_evt   = ~osc_run & ~sys_rst & ((|p6_wake) | p7_wake);
  wire                reset_req  = rst_i | ~pin_rst_n | wdt_reset;

  // ==================================================
  // start-up delay: one counter serves reset hold and wake stall
  always @(posedge clk_i) begin
    if (reset_req) begin
      ost_cnt_q      <= OST_CYC;
      ost_is_reset_q <= 1'b1;
      core_reset_o   <= 1'b1;
      core_stall_o   <= 1'b1;
    end else if (wake_evt) begin
      ost_cnt_q      <= OST_CYC;
      ost_is_reset_q <= 1'b0;
      core_stall_o   <= 1'b1;
    end else begin
      if (ost_cnt_q != {CNT_W{1'b0}}) begin
        ost_cnt_q <= ost_cnt_q - 1'b1;
      end
      core_reset_o <= ost_is_reset_q & (ost_cnt_q > 1);
      core_stall_o <= (ost_cnt_q > 1) | sleep1_q | ~osc_run;
    end
  end

  // ==================================================
  // counters: divider, watchdog base, prescaler, timer
  always @(posedge clk_i) begin
    if (sys_rst) begin
      div_q      <= 2'h0;
      wdt_base_q <= {CNT_W{1'b0}};
      presc_q    <= 8'h00;
      timer_q    <= 8'h00;
    end else begin
      div_q <= div_q + 2'h1;
      // watchdog base keeps running through both sleeps
      if (wdt_clear || wdt_evt) begin
        wdt_base_q <= {CNT_W{1'b0}};
      end else begin
        wdt_base_q <= wdt_base_q + 1'b1;
      end
      if ((wr_timer && !owner_wdt) || (wdt_clear && owner_wdt)) begin
        presc_q <= 8'h00;
      end else if (presc_evt) begin
        presc_q <= presc_full ? 8'h00 : presc_q + 8'h01;
      end
      // software write wins over a count in the same cycle
      if (wr_timer) begin
        timer_q <= wdat;
      end else if (timer_inc) begin
        timer_q <= timer_q + 8'h01;
      end
    end
  end

  // ==================================================
  // control registers
  always @(posedge clk_i) begin
    if (sys_rst) begin
      tcfg_q      <= `TWS_RST_TCFG;
      p5dir_q     <= `TWS_RST_DIR;
      p6dir_q     <= `TWS_RST_DIR;
      p7dir_q     <= `TWS_RST_DIR;
      p6wake_q    <= `TWS_RST_P6WAKE;
      wdslp_q     <= `TWS_RST_WDSLP;
      imask_q     <= `TWS_RST_ZERO;
      p5out_q     <= `TWS_RST_ZERO;
      p6out_q     <= `TWS_RST_ZERO;
      p7out_q     <= `TWS_RST_ZERO;
      sleep1_q    <= 1'b0;
      wdt_force_q <= 1'b0;
    end else begin
      if (wr_tcfg) begin
        tcfg_q[7] <= wdat[7];
        tcfg_q[5:0] <= wdat[5:0];
      end
      if (ops[`TWS_OP_GOFF] || ops[`TWS_OP_TAKEN]) begin
        tcfg_q[`TWS_TCFG_GIE] <= 1'b0;
      end else if (ops[`TWS_OP_GON] || ops[`TWS_OP_RETURN_FROM_IRQ_OP]) begin
        tcfg_q[`TWS_TCFG_GIE] <= 1'b1;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P5DIR) begin
        p5dir_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P6DIR) begin
        p6dir_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P7DIR) begin
        p7dir_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P6WAKE) begin
        p6wake_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_IMASK) begin
        imask_q <= wdat & `TWS_IRQ_MASK;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P5OUT) begin
        p5out_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P6OUT) begin
        p6out_q <= wdat;
      end
      if (wr_fire && adr_hi_ok && adr == `TWS_OFF_P7OUT) begin
        p7out_q <= wdat;
      end
      // a wake in the same cycle as a write keeps the run bit and enable set
      if (wake_evt) begin
        wdslp_q <= (wr_wdslp ? (wdat & `TWS_WDSLP_MASK) : wdslp_q)
                   | 8'h30;
        wdt_force_q <= 1'b1;
      end else if (wr_wdslp) begin
        wdslp_q     <= wdat & `TWS_WDSLP_MASK;
        wdt_force_q <= 1'b0;
      end
      if (op_sleep) begin
        sleep1_q <= 1'b1;
      end
    end
  end

  // ==================================================
  // interrupt flags: hardware set beats software clear
  wire                ext_fall   = ext_prev_q & ~ext_n;

  always @(posedge clk_i) begin
    if (sys_rst) begin
      iflag_q <= `TWS_RST_ZERO;
    end else begin
      iflag_q[`TWS_IRQ_TMR] <= (timer_inc && timer_q == 8'hFF && !wr_timer)
                               | (iflag_q[`TWS_IRQ_TMR]
                                  & ~(wr_iflag & ~wdat[`TWS_IRQ_TMR]));
      iflag_q[`TWS_IRQ_EXT] <= ext_fall
                               | (iflag_q[`TWS_IRQ_EXT] & ~(wr_iflag & ~wdat[`TWS_IRQ_EXT]));
    end
  end

  // ==================================================
  // pins and request outputs
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always @(posedge clk_i) begin
        if (sys_rst) begin
          p5_oe_n_o[gi] <= 1'b1;
          p6_oe_n_o[gi] <= 1'b1;
          p7_oe_n_o[gi] <= 1'b1;
        end else begin
          p5_oe_n_o[gi] <= p5dir_q[gi];
          p6_oe_n_o[gi] <= p6dir_q[gi];
          if (gi >= 6) begin
            p7_oe_n_o[gi] <= p7dir_q[gi] | (wdslp_q[`TWS_WD_ODE] & p7out_q[gi]);
          end else begin
            p7_oe_n_o[gi] <= p7dir_q[gi];
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_i) begin
    if (sys_rst) begin
      p5_o          <= 8'h00;
      p6_o          <= 8'h00;
      p7_o          <= 8'h00;
      p6_pullup_o   <= 8'h00;
      p7_pullup_o   <= 2'h0;
      irq_request_o <= 1'b0;
      osc_stop_o    <= 1'b0;
    end else begin
      p5_o          <= p5out_q;
      p6_o          <= p6out_q;
      p7_o          <= p7out_q;
      p6_pullup_o   <= {8{~tcfg_q[`TWS_TCFG_PULLN]}};
      p7_pullup_o   <= {2{~tcfg_q[`TWS_TCFG_PULLN]}};
      irq_request_o <= tcfg_q[`TWS_TCFG_GIE] & |(iflag_q & imask_q);
      osc_stop_o    <= ~osc_run;
    end
  end

  // ==================================================
  // wishbone read path, one wait state, unmapped reads return zero
  reg  [7:0]          rdat;

  always @* begin
    rdat = 8'h00;
    if (adr_hi_ok) begin
      case (adr)
        `TWS_OFF_TIMER:  rdat = timer_q;
        `TWS_OFF_TCFG:   rdat = tcfg_q;
        `TWS_OFF_P5DIR:  rdat = p5dir_q;
        `TWS_OFF_P6DIR:  rdat = p6dir_q;
        `TWS_OFF_P7DIR:  rdat = p7dir_q;
        `TWS_OFF_P6WAKE: rdat = p6wake_q;
        `TWS_OFF_WDSLP:  rdat = wdslp_q;
        `TWS_OFF_IMASK:  rdat = imask_q;
        `TWS_OFF_IFLAG:  rdat = iflag_q & imask_q;
        `TWS_OFF_STATUS: rdat = {2'h0, {2{wdslp_q[`TWS_WD_ROC]}} & p7_s2_q[1:0],
                                 wdt_active, core_stall_o, ~osc_run, sleep1_q};
        `TWS_OFF_P5OUT:  rdat = p5out_q;
        `TWS_OFF_P6OUT:  rdat = p6out_q;
        `TWS_OFF_P7OUT:  rdat = p7out_q;
        default:         rdat = 8'h00;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q    <= bus_req & ~ack_q;
      wb_ack_o <= bus_req & ~ack_q;
      if (bus_req && !ack_q) begin
        wb_dat_o <= {24'h000000, rdat};
      end
    end
  end

endmodule // tws_timer_watchdog

// ### verif/tws_timer_watchdog_assertions.sv
// port-level checker for the timer/watchdog/sleep block
// assumes a bind from the bench top; one clock, rst_i synchronous active high
`timescale 1ns/1ps
// ==================================================
// checker
module tws_timer_watchdog_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       reset_pin_n_i,
  input wire logic [7:0] p5_oe_n_o,
  input wire logic [7:0] p6_oe_n_o,
  input wire logic [7:0] p7_oe_n_o,
  input wire logic [7:0] p6_pullup_o,
  input wire logic [1:0] p7_pullup_o,
  input wire logic       irq_request_o,
  input wire logic       core_reset_o,
  input wire logic       core_stall_o,
  input wire logic       osc_stop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_start;
    $rose(wb_cyc_i & wb_stb_i);
  endsequence
  // two edges of margin: outputs are registered behind the reset state
  sequence held_rst;
    core_reset_o && $past(core_reset_o, 2);
  endsequence
  AST_ACK_ONE: assert property (req_start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer is not a single ack one cycle after request");
  AST_RST_HOLD: assert property ($fell(rst_i) |-> core_reset_o [*8])
    else $error("core left reset before the start-up delay");
  AST_PIN_RESET: assert property ($fell(reset_pin_n_i) |-> ##[1:6] core_reset_o)
    else $error("reset pin low did not reset the core");
  AST_RESET_PINS: assert property (held_rst |-> (p5_oe_n_o & p6_oe_n_o & p7_oe_n_o) == 8'hFF)
    else $error("a port pin drives during reset");
  AST_RESET_IRQ: assert property (held_rst |-> !irq_request_o && !osc_stop_o)
    else $error("irq or oscillator stop active during reset");
  AST_SLEEP_STALL: assert property (osc_stop_o && $past(osc_stop_o) |-> core_stall_o)
    else $error("core runs while the oscillator is stopped");
  AST_WAKE_OST: assert property ($fell(osc_stop_o) |-> core_stall_o [*8])
    else $error("wake-up skipped the start-up delay");
  AST_PULLUP_GROUP: assert property (p6_pullup_o == {8{p7_pullup_o[0]}}
    && p7_pullup_o[1] == p7_pullup_o[0])
    else $error("pull-up group split");
  AST_RESET_PULLUP: assert property (held_rst |-> p6_pullup_o == 8'h00)
    else $error("pull-ups on during reset");
endmodule // tws_timer_watchdog_assertions

// ### verif/tws_pin_model.sv
// pin-side model: timer input, reset pin, wake lines and resistor straps
// assumes the bench calls one task at a time; signals change just after clk_i
`timescale 1ns/1ps
// ==================================================
// pin model
module tws_pin_model #(
  parameter logic [7:0] P7_LEVEL = 8'hFE
) (
  input  wire logic       clk_i,
  output logic            timer_pin_o,
  output logic            reset_pin_n_o,
  output logic            ext_irq_n_o,
  output logic [7:0]      p6_o,
  output logic [7:0]      p7_o
);
  initial begin
    timer_pin_o = 1'b0;
    reset_pin_n_o = 1'b1;
    ext_irq_n_o = 1'b1;
    p6_o = 8'hFF;
    p7_o = P7_LEVEL;
  end
  // long low phase: design sees edges only after its synchroniser
  task pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      timer_pin_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      timer_pin_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
  task reset_pulse;
    @(posedge clk_i);
    reset_pin_n_o <= 1'b0;
    repeat (10) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
  endtask
  task wake(input int b);
    @(posedge clk_i);
    p6_o[b] <= 1'b0;
    repeat (6) @(posedge clk_i);
    p6_o[b] <= 1'b1;
  endtask
  task ext_pulse;
    @(posedge clk_i);
    ext_irq_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_irq_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // tws_pin_model

// ### verif/tws_timer_watchdog_tb.sv
// self-checking bench: wishbone register tasks plus pin model scenarios
// assumes short start-up and watchdog counts passed as parameters
`timescale 1ns/1ps
`include "tws_defs.vh"
// ==================================================
// bench top
module tws_timer_watchdog_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        fuse = 1'b1;
  logic        div = 1'b0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  int          err_count = 0;
  int          tests_run = 0;
  wire  [31:0] rdat;
  wire         ack, tmr, rpin_n, xirq_n, irq, c_rst, stall, ostop;
  wire  [7:0]  p5o, p5oe, p6o, p6oe, p7o, p7oe, p6pu, p6x, p7x;
  wire  [1:0]  p7pu;
  wire  [7:0]  p5i = (p5o & ~p5oe) | p5oe;
  wire  [7:0]  p6i = (p6o & ~p6oe) | (p6x & p6oe);
  wire  [7:0]  p7i = (p7o & ~p7oe) | (p7x & p7oe);
  always #4 clk_i = ~clk_i;
  tws_pin_model pin_i (.clk_i(clk_i), .timer_pin_o(tmr), .reset_pin_n_o(rpin_n),
    .ext_irq_n_o(xirq_n), .p6_o(p6x), .p7_o(p7x));
  tws_timer_watchdog #(.CNT_W(22), .OST_CYC(22'd20), .WDT_CYC(22'd40)) tws_timer_watchdog_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .reset_pin_n_i(rpin_n), .timer_pin_i(tmr), .ext_irq_n_i(xirq_n), .clk_div_opt_i(div),
    .watchdog_fuse_option_i(fuse), .p5_i(p5i), .p6_i(p6i), .p7_i(p7i), .p5_o(p5o),
    .p5_oe_n_o(p5oe), .p6_o(p6o), .p6_oe_n_o(p6oe), .p7_o(p7o), .p7_oe_n_o(p7oe),
    .p6_pullup_o(p6pu), .p7_pullup_o(p7pu), .irq_request_o(irq), .core_reset_o(c_rst),
    .core_stall_o(stall), .osc_stop_o(ostop));
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {26'h0, a};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 16) begin
      err_count++;
      complete_run();
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // k 0: core running, 1: core in reset, 2: oscillator back on
  task wait_on(input int k);
    int n;
    n = 0;
    while (n < 400 && !(k == 0 ? (c_rst === 1'b0 && stall === 1'b0) :
                        k == 1 ? c_rst === 1'b1 : ostop === 1'b0)) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      complete_run();
    end
  endtask
  logic [7:0] rst_val [9] = '{8'h00, 8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h31, 8'h00, 8'h00};
  logic [7:0] ops [4] = '{8'h01, 8'h02, 8'h04, 8'h20};
  logic [3:0] gexp = 4'b0101;
  initial begin
    int i;
    logic [7:0] t0, t1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_on(0);
    for (i = 0; i < 9; i++) rc(6'(i * 4), rst_val[i]);
    rc(6'h3C, 8'h00);
    for (i = 0; i < 3; i++) begin
      wr(6'(8 + i * 4), 8'h00);
      rc(6'(8 + i * 4), 8'h00);
    end
    chk(p5oe | p6oe, 8'h00);
    // no byte lane, no write
    sel <= 4'h0;
    wr(`TWS_OFF_P5OUT, 8'h55);
    sel <= 4'hF;
    rc(`TWS_OFF_P5OUT, 8'h00);
    wr(`TWS_OFF_P5OUT, 8'hA5);
    repeat (2) @(posedge clk_i);
    chk(p5o, 8'hA5);
    wr(`TWS_OFF_P7OUT, 8'hC0);
    wr(`TWS_OFF_WDSLP, 8'h71);
    // pin outputs trail the register by one clock
    repeat (2) @(posedge clk_i);
    chk({6'h0, p7oe[7:6]}, 8'h03);
    wr(`TWS_OFF_WDSLP, 8'h31);
    repeat (2) @(posedge clk_i);
    chk({6'h0, p7oe[7:6]}, 8'h00);
    wr(`TWS_OFF_TCFG, 8'h08);
    repeat (2) @(posedge clk_i);
    chk(p6pu, 8'hFF);
    chk({6'h0, p7pu}, 8'h03);
    // two reads 64 clocks apart: 16 ticks with divide option 1, 32 with 0
    for (i = 0; i < 2; i++) begin
      div <= (i == 0);
      repeat (4) @(posedge clk_i);
      wb(1'b0, `TWS_OFF_TIMER, 8'h00, t0);
      repeat (61) @(posedge clk_i);
      wb(1'b0, `TWS_OFF_TIMER, 8'h00, t1);
      chk(t1 - t0, (i == 0) ? 8'h10 : 8'h20);
    end
    // no prescaler on the timer: one count per two clocks
    wr(`TWS_OFF_TIMER, 8'hF0);
    wr(`TWS_OFF_IFLAG, 8'h00);
    repeat (60) @(posedge clk_i);
    rc(`TWS_OFF_IFLAG, 8'h00);
    wr(`TWS_OFF_IMASK, 8'h01);
    rc(`TWS_OFF_IFLAG, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(`TWS_OFF_OPS, ops[i]);
      rc(`TWS_OFF_TCFG, {1'b0, gexp[i], 6'h08});
      chk({7'h0, irq}, {7'h0, gexp[i]});
    end
    wr(`TWS_OFF_TCFG, 8'h28);
    wr(`TWS_OFF_IFLAG, 8'h00);
    rc(`TWS_OFF_IFLAG, 8'h00);
    wr(`TWS_OFF_IMASK, 8'h09);
    pin_i.ext_pulse();
    rc(`TWS_OFF_IFLAG, 8'h08);
    wr(`TWS_OFF_IMASK, 8'h01);
    rc(`TWS_OFF_IFLAG, 8'h00);
    for (i = 0; i < 2; i++) begin
      wr(`TWS_OFF_TCFG, 8'h28 | 8'(i << 4));
      wr(`TWS_OFF_TIMER, 8'h00);
      pin_i.pulse(5);
      rc(`TWS_OFF_TIMER, 8'h05);
    end
    wr(`TWS_OFF_TCFG, 8'h20);
    wr(`TWS_OFF_TIMER, 8'h00);
    pin_i.pulse(6);
    rc(`TWS_OFF_TIMER, 8'h03);
    pin_i.pulse(1);
    wr(`TWS_OFF_TIMER, 8'h00);
    pin_i.pulse(1);
    rc(`TWS_OFF_TIMER, 8'h00);
    // slow watchdog so the forced one cannot fire before it is turned off
    wr(`TWS_OFF_TCFG, 8'h0F);
    wr(`TWS_OFF_OPS, 8'h08);
    wr(`TWS_OFF_P6DIR, 8'hFF);
    wr(`TWS_OFF_P6WAKE, 8'hFE);
    rc(`TWS_OFF_P6WAKE, 8'hFE);
    wr(`TWS_OFF_WDSLP, 8'h21);
    repeat (4) @(posedge clk_i);
    chk({7'h0, ostop}, 8'h01);
    pin_i.wake(0);
    wait_on(2);
    chk({7'h0, stall}, 8'h01);
    rc(`TWS_OFF_WDSLP, 8'h31);
    wr(`TWS_OFF_WDSLP, 8'h11);
    wait_on(0);
    wr(`TWS_OFF_OPS, 8'h10);
    rc(`TWS_OFF_STATUS, 8'h05);
    pin_i.reset_pulse();
    wait_on(1);
    chk({7'h0, c_rst}, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(p5oe & p6oe & p7oe, 8'hFF);
    wait_on(0);
    rc(`TWS_OFF_TCFG, 8'hBF);
    rc(`TWS_OFF_WDSLP, 8'h31);
    rc(`TWS_OFF_STATUS, 8'h00);
    wr(`TWS_OFF_WDSLP, 8'h39);
    rc(`TWS_OFF_STATUS, 8'h20);
    fuse <= 1'b0;
    wr(`TWS_OFF_WDSLP, 8'h11);
    wr(`TWS_OFF_TCFG, 8'hB8);
    repeat (120) @(posedge clk_i);
    chk({7'h0, c_rst}, 8'h00);
    wr(`TWS_OFF_WDSLP, 8'h31);
    wait_on(1);
    chk({7'h0, c_rst}, 8'h01);
    complete_run();
  end
endmodule // tws_timer_watchdog_tb
bind tws_timer_watchdog tws_timer_watchdog_assertions tws_timer_watchdog_assertions_i (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .reset_pin_n_i, .p5_oe_n_o, .p6_oe_n_o,
  .p7_oe_n_o, .p6_pullup_o, .p7_pullup_o, .irq_request_o, .core_reset_o, .core_stall_o,
  .osc_stop_o);
